// File: asf_pkg.sv
// Shared constants, types and helpers of the serial audio format engine.
// Assumes both link ends run on one core clock and sample link pins synchronously.
package asf_pkg;

  // ****************************************
  // Framing formats and slot decoding
  // ****************************************
  typedef enum logic [1:0] {
    ASF_FMT_RSVD = 2'h0,
    ASF_FMT_LJ   = 2'h1,
    ASF_FMT_DSP  = 2'h3,
    ASF_FMT_I2S  = 2'h2
  } asf_fmt_t;

  typedef struct packed {
    logic       valid;
    logic       right;
    logic [4:0] pos;
  } asf_slot_t;

  localparam int FRAME_BITS_DEF = 64;
  localparam logic [7:0] K_MAX = 8'hFF;

  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [7:0] SFC_ADDR = 8'h04;
  localparam logic [7:0] CLK_ADDR = 8'h06;
  localparam logic [7:0] PBC_ADDR = 8'h15;
  localparam logic [7:0] CPC_ADDR = 8'h19;
  localparam logic [7:0] DST_ADDR = 8'h1F;
  localparam logic [15:0] SFC_RESET = 16'h020A;
  localparam logic [15:0] CLK_RESET = 16'h0006;
  localparam logic [15:0] SFC_MASK = 16'h037F;
  localparam logic [15:0] CLK_MASK = 16'h000F;
  localparam logic [15:0] PBC_MASK = 16'h0001;
  localparam logic [15:0] CPC_MASK = 16'h0003;
  localparam int FMT_LSB = 0;
  localparam int WL_LSB = 2;
  localparam int FPOL_BIT = 4;
  localparam int BINV_BIT = 5;
  localparam int PBSEL_BIT = 6;
  localparam int LSRC_BIT = 8;
  localparam int RSRC_BIT = 9;
  localparam int MASTER_SELECT_BIT = 0;
  localparam int DIV_LSB = 1;
  localparam int LINV_BIT = 0;
  localparam int RINV_BIT = 1;

  // ****************************************
  // Host controller register map
  // ****************************************
  localparam logic [7:0] H_CFG_ADDR = 8'h00;
  localparam logic [7:0] H_TXL_ADDR = 8'h04;
  localparam logic [7:0] H_TXR_ADDR = 8'h08;
  localparam logic [7:0] H_RXL_ADDR = 8'h0C;
  localparam logic [7:0] H_RXR_ADDR = 8'h10;
  localparam logic [7:0] H_ST_ADDR = 8'h14;
  localparam logic [31:0] H_CFG_RESET = 32'h0000_01CA;
  localparam logic [31:0] H_CFG_MASK = 32'h0000_03FF;
  localparam int H_MASTER_SELECT_BIT = 6;
  localparam int H_DIV_LSB = 7;

  function automatic logic [5:0] wl_bits(input logic [1:0] wl);
    case (wl)
      2'h0: return 6'h10;
      2'h1: return 6'h14;
      2'h2: return 6'h18;
      default: return 6'h20;
    endcase
  endfunction : wl_bits

  // Maps the rising-edge index since frame event to channel and bit position.
  function automatic asf_slot_t slot_of(input logic [1:0] fmt, input logic modeb,
                                        input logic [1:0] wl, input logic [7:0] k,
                                        input logic right_lvl);
    asf_slot_t s;
    logic [8:0] q;
    logic [8:0] n;
    s = '0;
    n = {3'h0, wl_bits(wl)};
    case (fmt)
      ASF_FMT_LJ: q = {1'b0, k};
      ASF_FMT_I2S: q = {1'b0, k} - 9'h001;
      ASF_FMT_DSP: q = {1'b0, k} - {8'h00, ~modeb};
      default: q = 9'h1FF;
    endcase
    if (fmt == ASF_FMT_DSP) begin
      s.valid = q < (n << 1);
      s.right = q >= n;
      s.pos = s.right ? 5'(q - n) : q[4:0];
    end else begin
      s.valid = (fmt != ASF_FMT_RSVD) && (q < n);
      s.right = right_lvl;
      s.pos = q[4:0];
    end
    return s;
  endfunction : slot_of

  // Negation with the most negative code clipped to the most positive.
  function automatic logic [31:0] neg_sat(input logic [31:0] w);
    return (w == 32'h8000_0000) ? 32'h7FFF_FFFF : (~w + 32'h0000_0001);
  endfunction : neg_sat

endpackage : asf_pkg

// File: asf_link_if.sv
// Serial audio link between the converter device end and the host end.
// Assumes both ends share the core clock; the wire levels are resolved here.
`timescale 1ns/1ps
`default_nettype none
interface asf_link_if;
  logic bclk_dev;
  logic bclk_dev_oe;
  logic frame_dev;
  logic frame_dev_oe;
  logic bclk_host;
  logic bclk_host_oe;
  logic frame_host;
  logic frame_host_oe;
  logic cap_data;
  logic pb_data;
  logic bclk;
  logic frame;

  // The device end wins if both ends drive the clocks.
  assign bclk = bclk_dev_oe ? bclk_dev : (bclk_host_oe & bclk_host);
  assign frame = frame_dev_oe ? frame_dev : (frame_host_oe & frame_host);

  modport dev (
    output bclk_dev, bclk_dev_oe, frame_dev, frame_dev_oe, cap_data,
    input bclk, frame, pb_data
  );
  modport host (
    output bclk_host, bclk_host_oe, frame_host, frame_host_oe, pb_data,
    input bclk, frame, cap_data
  );
endinterface : asf_link_if
`default_nettype wire

// File: asf_device.sv
// Converter-side end of the serial audio link: formats capture samples out, takes playback in.
// Assumes a single core clock; link pins are sampled on it and registers sit on a plain port.
// Operation
// - Format field selects LJ, I2S or DSP.
// - Every word shifts most significant bit first.
// - Word length field selects 16/20/24/32 bits.
// - LJ top bit on first edge.
// - LJ trailing bit clocks carry nothing.
// - I2S top bit on second edge.
// - I2S gap cycles are ignored.
// - DSP mode A second, mode B first edge.
// - Bit 4 picks submode or frame polarity.
// - DSP right word follows left directly.
// - DSP trailing cycles carry no data.
// - Slave frame pulse ends before next.
// - Master DSP frame is short pulse.
// - Default stereo: left capture input in left slot, right input in right slot.
// - Bit 9 picks right slot source.
// - Bit 8 picks left slot source.
// - Bit 6 picks playback slot.
// - Bit 5 inverts bit clock polarity.
// - Playback invert bit negates received data.
// - Capture invert bits negate outgoing samples.
// - Master drives clocks, slave receives them.
// - Divider code sets master bit clock rate.
`timescale 1ns/1ps
`default_nettype none
module asf_device #(
  parameter int FRAME_BITS = asf_pkg::FRAME_BITS_DEF
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic [31:0] CAP_LEFT_I,
  input wire logic [31:0] CAP_RIGHT_I,
  output logic CAP_TAKE_O,
  output logic [31:0] PB_DATA_O,
  output logic PB_VALID_O,
  asf_link_if.dev LINK
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] sfc_ff;
  logic [15:0] clk_ff;
  logic [15:0] pbc_ff;
  logic [15:0] cpc_ff;
  logic [15:0] rd_mux;
  logic [7:0] k_ff;
  logic fr_rise_ff;

  wire logic wr_sfc = REG_WR_I & (REG_ADDR_I == asf_pkg::SFC_ADDR);
  wire logic wr_clk = REG_WR_I & (REG_ADDR_I == asf_pkg::CLK_ADDR);
  wire logic wr_pbc = REG_WR_I & (REG_ADDR_I == asf_pkg::PBC_ADDR);
  wire logic wr_cpc = REG_WR_I & (REG_ADDR_I == asf_pkg::CPC_ADDR);

  always_comb begin
    if (REG_ADDR_I == asf_pkg::SFC_ADDR) begin
      rd_mux = sfc_ff;
    end else if (REG_ADDR_I == asf_pkg::CLK_ADDR) begin
      rd_mux = clk_ff;
    end else if (REG_ADDR_I == asf_pkg::PBC_ADDR) begin
      rd_mux = pbc_ff;
    end else if (REG_ADDR_I == asf_pkg::CPC_ADDR) begin
      rd_mux = cpc_ff;
    end else if (REG_ADDR_I == asf_pkg::DST_ADDR) begin
      rd_mux = {7'h00, fr_rise_ff, k_ff};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sfc_ff <= asf_pkg::SFC_RESET;
      clk_ff <= asf_pkg::CLK_RESET;
      pbc_ff <= 16'h0000;
      cpc_ff <= 16'h0000;
      REG_RDATA_O <= 16'h0000;
    end else begin
      if (wr_sfc) begin
        sfc_ff <= REG_WDATA_I & asf_pkg::SFC_MASK;
      end
      if (wr_clk) begin
        clk_ff <= REG_WDATA_I & asf_pkg::CLK_MASK;
      end
      if (wr_pbc) begin
        pbc_ff <= REG_WDATA_I & asf_pkg::PBC_MASK;
      end
      if (wr_cpc) begin
        cpc_ff <= REG_WDATA_I & asf_pkg::CPC_MASK;
      end
      REG_RDATA_O <= REG_RD_I ? rd_mux : 16'h0000;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  // format select
  wire logic [1:0] fmt = sfc_ff[asf_pkg::FMT_LSB +: 2];
  wire logic [1:0] wl = sfc_ff[asf_pkg::WL_LSB +: 2];
  wire logic [5:0] n = asf_pkg::wl_bits(wl);
  wire logic fpol = sfc_ff[asf_pkg::FPOL_BIT];
  wire logic binv = sfc_ff[asf_pkg::BINV_BIT];
  wire logic pbsel = sfc_ff[asf_pkg::PBSEL_BIT];
  wire logic master_select = clk_ff[asf_pkg::MASTER_SELECT_BIT];
  wire logic [2:0] div = clk_ff[asf_pkg::DIV_LSB +: 3];
  wire logic is_dsp = fmt == asf_pkg::ASF_FMT_DSP;
  wire logic is_lj = fmt == asf_pkg::ASF_FMT_LJ;

  // ****************************************
  // Master clock and frame generation
  // ****************************************
  logic [5:0] div_cnt_ff;
  logic [7:0] bc_ff;
  logic bclk_ff;
  logic frame_ff;
  logic oe_ff;

  wire logic [5:0] half_m1 = (6'h01 << div) - 6'h01;
  wire logic tick = div_cnt_ff == half_m1;
  wire logic mfall = master_select & tick & (bclk_ff ^ binv);
  wire logic [7:0] bc_nxt = (bc_ff == 8'(FRAME_BITS - 1)) ? 8'h00 : bc_ff + 8'h01;
  wire logic left_half = bc_nxt < 8'(FRAME_BITS / 2);
  // one bit-clock frame pulse in DSP
  wire logic fr_gen = is_dsp ? (bc_nxt == 8'h00) : ((left_half ~^ is_lj) ^ fpol);

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_cnt_ff <= 6'h00;
      bc_ff <= 8'h00;
      bclk_ff <= 1'b0;
      frame_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      div_cnt_ff <= (tick | ~master_select) ? 6'h00 : div_cnt_ff + 6'h01;
      if (master_select & tick) begin
        bclk_ff <= ~bclk_ff;
      end
      if (mfall) begin
        bc_ff <= bc_nxt;
        frame_ff <= fr_gen;
      end
      oe_ff <= master_select;
    end
  end

  assign LINK.bclk_dev = bclk_ff;
  assign LINK.frame_dev = frame_ff;
  assign LINK.bclk_dev_oe = oe_ff;
  assign LINK.frame_dev_oe = oe_ff;

  // ****************************************
  // Bit timing and slot tracking
  // ****************************************
  logic eprev_ff;
  asf_pkg::asf_slot_t slot;

  wire logic raw_up = LINK.bclk & ~eprev_ff;
  wire logic raw_dn = ~LINK.bclk & eprev_ff;
  wire logic rise = binv ? raw_dn : raw_up;
  wire logic fall = binv ? raw_up : raw_dn;
  // polarity in LJ and I2S only
  wire logic frl = is_dsp ? LINK.frame : (LINK.frame ^ fpol);
  wire logic ev = is_dsp ? (frl & ~fr_rise_ff) : (frl ^ fr_rise_ff);
  wire logic right_lvl = is_lj ? ~frl : frl;
  wire logic [7:0] k_nxt = ev ? 8'h00 : ((k_ff == asf_pkg::K_MAX) ? k_ff : k_ff + 8'h01);
  assign slot = asf_pkg::slot_of(fmt, fpol, wl, k_nxt, right_lvl);
  wire logic last = slot.valid & (slot.pos == 5'(n - 6'h01));

  // ****************************************
  // Receive path
  // ****************************************
  logic [31:0] rxl_ff;
  logic [31:0] rxr_ff;

  wire logic [31:0] nxt_rxl = (rise & slot.valid & ~slot.right) ? {rxl_ff[30:0], LINK.pb_data}
                                                                 : rxl_ff;
  wire logic [31:0] nxt_rxr = (rise & slot.valid & slot.right) ? {rxr_ff[30:0], LINK.pb_data}
                                                                : rxr_ff;
  wire logic done = rise & last & (slot.right == pbsel);
  wire logic [31:0] pb_raw = (pbsel ? nxt_rxr : nxt_rxl) << (6'd32 - n);
  wire logic [31:0] mask = ~(32'hFFFF_FFFF >> n);
  wire logic [31:0] pb_word = (pbc_ff[0] ? asf_pkg::neg_sat(pb_raw) : pb_raw) & mask;

  // ****************************************
  // Transmit path
  // ****************************************
  logic [31:0] txl_ff;
  logic [31:0] txr_ff;
  logic data_ff;

  wire logic [31:0] capl = cpc_ff[asf_pkg::LINV_BIT] ? asf_pkg::neg_sat(CAP_LEFT_I) : CAP_LEFT_I;
  wire logic [31:0] capr = cpc_ff[asf_pkg::RINV_BIT] ? asf_pkg::neg_sat(CAP_RIGHT_I) : CAP_RIGHT_I;
  wire logic [31:0] srcl = sfc_ff[asf_pkg::LSRC_BIT] ? capr : capl;
  wire logic [31:0] srcr = sfc_ff[asf_pkg::RSRC_BIT] ? capr : capl;
  wire logic latch = fall & ev & (is_dsp | ~right_lvl);
  wire logic [31:0] wl_now = latch ? srcl : txl_ff;
  wire logic [31:0] wr_now = latch ? srcr : txr_ff;
  wire logic [4:0] bit_ix = 5'd31 - slot.pos;
  wire logic tx_bit = slot.valid & (slot.right ? wr_now[bit_ix] : wl_now[bit_ix]);

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      eprev_ff <= 1'b0;
      k_ff <= asf_pkg::K_MAX;
      fr_rise_ff <= 1'b0;
      rxl_ff <= 32'h0000_0000;
      rxr_ff <= 32'h0000_0000;
      txl_ff <= 32'h0000_0000;
      txr_ff <= 32'h0000_0000;
      data_ff <= 1'b0;
      PB_DATA_O <= 32'h0000_0000;
      PB_VALID_O <= 1'b0;
      CAP_TAKE_O <= 1'b0;
    end else begin
      eprev_ff <= LINK.bclk;
      rxl_ff <= nxt_rxl;
      rxr_ff <= nxt_rxr;
      if (rise) begin
        k_ff <= k_nxt;
        fr_rise_ff <= frl;
      end
      if (fall) begin
        data_ff <= tx_bit;
      end
      if (latch) begin
        txl_ff <= srcl;
        txr_ff <= srcr;
      end
      if (done) begin
        PB_DATA_O <= pb_word;
      end
      PB_VALID_O <= done;
      CAP_TAKE_O <= latch;
    end
  end

  assign LINK.cap_data = data_ff;

endmodule : asf_device
`default_nettype wire

// File: asf_host.sv
// Host end of the serial audio link: sends playback words, collects capture words.
// Assumes the same core clock as the device end; orders arrive over a plain register port.
`timescale 1ns/1ps
`default_nettype none
module asf_host #(
  parameter int FRAME_BITS = asf_pkg::FRAME_BITS_DEF
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  asf_link_if.host LINK
);

  logic [31:0] cfg_ff;
  logic [31:0] txl_ff;
  logic [31:0] txr_ff;
  logic [31:0] rxl_ff;
  logic [31:0] rxr_ff;
  logic [31:0] hl_ff;
  logic [31:0] hr_ff;
  logic [15:0] fcnt_ff;
  logic [31:0] rd_mux;
  logic [7:0] k_ff;
  logic fr_rise_ff;
  logic eprev_ff;
  logic [31:0] sl_ff;
  logic [31:0] sr_ff;
  logic data_ff;
  logic [5:0] div_cnt_ff;
  logic [7:0] bc_ff;
  logic bclk_ff;
  logic frame_ff;
  logic oe_ff;
  asf_pkg::asf_slot_t slot;

  always_comb begin
    if (REG_ADDR_I == asf_pkg::H_CFG_ADDR) begin
      rd_mux = cfg_ff;
    end else if (REG_ADDR_I == asf_pkg::H_TXL_ADDR) begin
      rd_mux = txl_ff;
    end else if (REG_ADDR_I == asf_pkg::H_TXR_ADDR) begin
      rd_mux = txr_ff;
    end else if (REG_ADDR_I == asf_pkg::H_RXL_ADDR) begin
      rd_mux = hl_ff;
    end else if (REG_ADDR_I == asf_pkg::H_RXR_ADDR) begin
      rd_mux = hr_ff;
    end else if (REG_ADDR_I == asf_pkg::H_ST_ADDR) begin
      rd_mux = {16'h0000, fcnt_ff};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  wire logic [1:0] fmt = cfg_ff[asf_pkg::FMT_LSB +: 2];
  wire logic [1:0] wl = cfg_ff[asf_pkg::WL_LSB +: 2];
  wire logic [5:0] n = asf_pkg::wl_bits(wl);
  wire logic fpol = cfg_ff[asf_pkg::FPOL_BIT];
  wire logic binv = cfg_ff[asf_pkg::BINV_BIT];
  wire logic master_select = cfg_ff[asf_pkg::H_MASTER_SELECT_BIT];
  wire logic [2:0] div = cfg_ff[asf_pkg::H_DIV_LSB +: 3];
  wire logic is_dsp = fmt == asf_pkg::ASF_FMT_DSP;
  wire logic is_lj = fmt == asf_pkg::ASF_FMT_LJ;

  // ****************************************
  // Clock and frame generation as master
  // ****************************************
  wire logic [5:0] half_m1 = (6'h01 << div) - 6'h01;
  wire logic tick = div_cnt_ff == half_m1;
  wire logic mfall = master_select & tick & (bclk_ff ^ binv);
  wire logic [7:0] bc_nxt = (bc_ff == 8'(FRAME_BITS - 1)) ? 8'h00 : bc_ff + 8'h01;
  wire logic left_half = bc_nxt < 8'(FRAME_BITS / 2);
  wire logic fr_gen = is_dsp ? (bc_nxt == 8'h00) : ((left_half ~^ is_lj) ^ fpol);

  // ****************************************
  // Slot tracking, shifting and sampling
  // ****************************************
  // raw edges, swapped below when bit 5 inverts the bit clock
  wire logic raw_up = LINK.bclk & ~eprev_ff;
  wire logic raw_dn = ~LINK.bclk & eprev_ff;
  wire logic rise = binv ? raw_dn : raw_up;
  wire logic fall = binv ? raw_up : raw_dn;
  wire logic frl = is_dsp ? LINK.frame : (LINK.frame ^ fpol);
  wire logic ev = is_dsp ? (frl & ~fr_rise_ff) : (frl ^ fr_rise_ff);
  wire logic right_lvl = is_lj ? ~frl : frl;
  wire logic [7:0] k_nxt = ev ? 8'h00 : ((k_ff == asf_pkg::K_MAX) ? k_ff : k_ff + 8'h01);
  assign slot = asf_pkg::slot_of(fmt, fpol, wl, k_nxt, right_lvl);
  wire logic last = slot.valid & (slot.pos == 5'(n - 6'h01));
  wire logic [31:0] nxt_rxl = (rise & slot.valid & ~slot.right) ? {rxl_ff[30:0], LINK.cap_data}
                                                                 : rxl_ff;
  wire logic [31:0] nxt_rxr = (rise & slot.valid & slot.right) ? {rxr_ff[30:0], LINK.cap_data}
                                                                : rxr_ff;
  wire logic fdone = rise & last & slot.right;
  wire logic latch = fall & ev & (is_dsp | ~right_lvl);
  wire logic [31:0] wl_now = latch ? txl_ff : sl_ff;
  wire logic [31:0] wr_now = latch ? txr_ff : sr_ff;
  wire logic [4:0] bit_ix = 5'd31 - slot.pos;
  wire logic tx_bit = slot.valid & (slot.right ? wr_now[bit_ix] : wl_now[bit_ix]);

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cfg_ff <= asf_pkg::H_CFG_RESET;
      txl_ff <= 32'h0000_0000;
      txr_ff <= 32'h0000_0000;
      REG_RDATA_O <= 32'h0000_0000;
    end else begin
      if (REG_WR_I & (REG_ADDR_I == asf_pkg::H_CFG_ADDR)) begin
        cfg_ff <= REG_WDATA_I & asf_pkg::H_CFG_MASK;
      end
      if (REG_WR_I & (REG_ADDR_I == asf_pkg::H_TXL_ADDR)) begin
        txl_ff <= REG_WDATA_I;
      end
      if (REG_WR_I & (REG_ADDR_I == asf_pkg::H_TXR_ADDR)) begin
        txr_ff <= REG_WDATA_I;
      end
      REG_RDATA_O <= REG_RD_I ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_cnt_ff <= 6'h00;
      bc_ff <= 8'h00;
      bclk_ff <= 1'b0;
      frame_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      div_cnt_ff <= (tick | ~master_select) ? 6'h00 : div_cnt_ff + 6'h01;
      if (master_select & tick) begin
        bclk_ff <= ~bclk_ff;
      end
      if (mfall) begin
        bc_ff <= bc_nxt;
        frame_ff <= fr_gen;
      end
      oe_ff <= master_select;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      eprev_ff <= 1'b0;
      k_ff <= asf_pkg::K_MAX;
      fr_rise_ff <= 1'b0;
      rxl_ff <= 32'h0000_0000;
      rxr_ff <= 32'h0000_0000;
      hl_ff <= 32'h0000_0000;
      hr_ff <= 32'h0000_0000;
      fcnt_ff <= 16'h0000;
      sl_ff <= 32'h0000_0000;
      sr_ff <= 32'h0000_0000;
      data_ff <= 1'b0;
    end else begin
      eprev_ff <= LINK.bclk;
      rxl_ff <= nxt_rxl;
      rxr_ff <= nxt_rxr;
      if (rise) begin
        k_ff <= k_nxt;
        fr_rise_ff <= frl;
      end
      if (fall) begin
        data_ff <= tx_bit;
      end
      if (latch) begin
        sl_ff <= txl_ff;
        sr_ff <= txr_ff;
      end
      if (fdone) begin
        hl_ff <= nxt_rxl << (6'd32 - n);
        hr_ff <= nxt_rxr << (6'd32 - n);
        fcnt_ff <= fcnt_ff + 16'h0001;
      end
    end
  end

  assign LINK.bclk_host = bclk_ff;
  assign LINK.frame_host = frame_ff;
  assign LINK.bclk_host_oe = oe_ff;
  assign LINK.frame_host_oe = oe_ff;
  assign LINK.pb_data = data_ff;

endmodule : asf_host
`default_nettype wire

// File: asf_link_sva.sv
// Assertions on the link wires between the device end and the host end.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module asf_link_sva (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic bclk_dev,
  input wire logic bclk_dev_oe,
  input wire logic frame_dev,
  input wire logic frame_dev_oe,
  input wire logic bclk_host,
  input wire logic bclk_host_oe,
  input wire logic frame_host,
  input wire logic frame_host_oe,
  input wire logic cap_data,
  input wire logic pb_data,
  input wire logic bclk,
  input wire logic frame
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  logic [1:0] bclk_q_ff;
  wire logic last_edge;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bclk_q_ff <= 2'h0;
    end else begin
      bclk_q_ff <= {bclk_q_ff[0], bclk};
    end
  end
  // Data may only move in the core cycle after a bit-clock edge was seen.
  assign last_edge = bclk_q_ff[0] ^ bclk_q_ff[1];
  a_bclk_resolve: assert property (bclk_dev_oe |-> bclk == bclk_dev)
    else $error("bit clock does not follow device");
  a_frame_resolve: assert property (frame_host_oe && !frame_dev_oe |-> frame == frame_host)
    else $error("frame does not follow host");
  a_dev_pair: assert property (bclk_dev_oe |-> frame_dev_oe)
    else $error("device drives bit clock alone");
  a_host_pair: assert property (bclk_host_oe |-> frame_host_oe)
    else $error("host drives bit clock alone");
  a_dframe_on_edge: assert property (frame_dev_oe && $past(frame_dev_oe) && $changed(frame_dev)
    |-> $changed(bclk_dev))
    else $error("device frame moved off a bit clock edge");
  a_cap_on_edge: assert property ($changed(cap_data) |-> last_edge)
    else $error("capture data moved off an edge");
  a_pb_on_edge: assert property ($changed(pb_data) |-> last_edge)
    else $error("playback data moved off an edge");
  a_hbclk_runs: assert property (bclk_host_oe |-> ##[1:66] ($changed(bclk_host) || !bclk_host_oe))
    else $error("host bit clock stalled");
  a_dbclk_runs: assert property (bclk_dev_oe |-> ##[1:66] ($changed(bclk_dev) || !bclk_dev_oe))
    else $error("device bit clock stalled");
  c_dev_master: cover property ($rose(bclk_dev_oe));
  c_cap_bit: cover property ($rose(cap_data));
  c_host_frame: cover property (frame_host_oe && $changed(frame_host));
endmodule : asf_link_sva
`default_nettype wire

// File: tb_audio_serial_format_engine.sv
// Bench joining both link ends and driving them through their register ports.
// Assumes one shared core clock; expected words are worked out by hand.
`timescale 1ns/1ps
`default_nettype none
module tb_audio_serial_format_engine;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic d_wr = 1'b0, d_rd = 1'b0, h_wr = 1'b0, h_rd = 1'b0;
  logic [31:0] cap_l = 32'h0, cap_r = 32'h0, h_rdata, pb_word;
  logic [15:0] d_rdata;
  logic pb_valid, cap_take;
  int num_errors = 0, n_checks = 0, cycles = 0;
  int n_take = 0, n_pbv = 0;
  asf_link_if i_asf_link_if ();
  asf_device i_asf_device (.CORE_CLK_I(core_clk), .RESETN_I(resetn), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd[15:0]), .REG_WR_I(d_wr), .REG_RD_I(d_rd), .REG_RDATA_O(d_rdata),
    .CAP_LEFT_I(cap_l), .CAP_RIGHT_I(cap_r), .CAP_TAKE_O(cap_take), .PB_DATA_O(pb_word),
    .PB_VALID_O(pb_valid), .LINK(i_asf_link_if));
  asf_host i_asf_host (.CORE_CLK_I(core_clk), .RESETN_I(resetn), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_WR_I(h_wr), .REG_RD_I(h_rd), .REG_RDATA_O(h_rdata),
    .LINK(i_asf_link_if));
  asf_link_sva i_asf_link_sva (.CORE_CLK_I(core_clk), .RESETN_I(resetn),
    .bclk_dev(i_asf_link_if.bclk_dev), .bclk_dev_oe(i_asf_link_if.bclk_dev_oe),
    .frame_dev(i_asf_link_if.frame_dev), .frame_dev_oe(i_asf_link_if.frame_dev_oe),
    .bclk_host(i_asf_link_if.bclk_host), .bclk_host_oe(i_asf_link_if.bclk_host_oe),
    .frame_host(i_asf_link_if.frame_host), .frame_host_oe(i_asf_link_if.frame_host_oe),
    .cap_data(i_asf_link_if.cap_data), .pb_data(i_asf_link_if.pb_data),
    .bclk(i_asf_link_if.bclk), .frame(i_asf_link_if.frame));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cap_take) n_take++;
    if (pb_valid) n_pbv++;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One register access: h picks the host port, w picks a write.
  task automatic acc(input bit h, input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wd <= d;
    d_wr <= !h && w;
    d_rd <= !h && !w;
    h_wr <= h && w;
    h_rd <= h && !w;
    @(posedge core_clk);
    {d_wr, d_rd, h_wr, h_rd} <= 4'h0;
    #1 v = h ? h_rdata : {16'h0000, d_rdata};
  endtask : acc
  task automatic wr(input bit h, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    acc(h, 1'b1, a, d, v);
  endtask : wr
  task automatic rd(input bit h, input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    acc(h, 1'b0, a, 32'h0, v);
    chk(nm, v, e);
  endtask : rd
  task automatic wait_frames(input int n);
    logic [31:0] c0, c;
    acc(1'b1, 1'b0, asf_pkg::H_ST_ADDR, 32'h0, c0);
    c = c0;
    for (int i = 0; i < 4000 && c < c0 + n; i++) acc(1'b1, 1'b0, asf_pkg::H_ST_ADDR, 32'h0, c);
    chk("frame count", 32'(c >= c0 + n), 32'h1);
  endtask : wait_frames
  task automatic stream(input logic [15:0] sfc, input logic [15:0] clk, input logic [31:0] cfg,
                        input logic [31:0] cl, input logic [31:0] cr, input logic [31:0] tl,
                        input logic [31:0] tr, input logic [31:0] el, input logic [31:0] er,
                        input logic [31:0] ep);
    int t0, p0;
    @(posedge core_clk);
    cap_l <= cl;
    cap_r <= cr;
    wr(1'b1, asf_pkg::H_TXL_ADDR, tl);
    wr(1'b1, asf_pkg::H_TXR_ADDR, tr);
    wr(1'b1, asf_pkg::H_CFG_ADDR, cfg);
    wr(1'b0, asf_pkg::CLK_ADDR, {16'h0000, clk});
    wr(1'b0, asf_pkg::SFC_ADDR, {16'h0000, sfc});
    t0 = n_take;
    p0 = n_pbv;
    wait_frames(3);
    rd(1'b1, asf_pkg::H_RXL_ADDR, el, "left word");
    rd(1'b1, asf_pkg::H_RXR_ADDR, er, "right word");
    chk("playback word", pb_word, ep);
    chk("capture takes", 32'((n_take - t0 >= 2) && (n_take - t0 <= 5)), 32'h1);
    chk("playback strobes", 32'((n_pbv - p0 >= 2) && (n_pbv - p0 <= 5)), 32'h1);
  endtask : stream
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic regs_after_reset();
    rd(1'b0, asf_pkg::SFC_ADDR, 32'h0000_020A, "format reg");
    rd(1'b0, asf_pkg::CLK_ADDR, 32'h0000_0006, "clock reg");
    rd(1'b0, asf_pkg::CPC_ADDR, 32'h0, "capture reg");
    rd(1'b0, 8'h33, 32'h0, "unmapped reg");
    rd(1'b1, asf_pkg::H_CFG_ADDR, 32'h0000_01CA, "host cfg");
    wr(1'b0, asf_pkg::PBC_ADDR, 32'hFFFF);
    rd(1'b0, asf_pkg::PBC_ADDR, 32'h0000_0001, "playback reg");
  endtask : regs_after_reset
  task automatic i2s_default();
    wr(1'b0, asf_pkg::PBC_ADDR, 32'h0);
    stream(16'h020A, 16'h0006, 32'h1CA, 32'hA5C3_E1FF, 32'h1234_5678, 32'h8765_4321,
           32'h1111_1111, 32'hA5C3_E100, 32'h1234_5600, 32'h8765_4300);
  endtask : i2s_default
  task automatic lj_inverted();
    stream(16'h0235, 16'h0006, 32'h1F5, 32'hFFFF_FFFF, 32'h0000_1000, 32'h0000_1FFF,
           32'hFFFF_FFFF, 32'hFFFF_F000, 32'h0000_1000, 32'h0000_1000);
  endtask : lj_inverted
  task automatic dsp_a_dev_master();
    stream(16'h000B, 16'h0007, 32'h18B, 32'h0F0F_0F0F, 32'hFFFF_FFFF, 32'h3C3C_3C3C,
           32'hC3C3_C3C3, 32'h0F0F_0F00, 32'h0F0F_0F00, 32'h3C3C_3C00);
  endtask : dsp_a_dev_master
  task automatic dsp_b_negated();
    wr(1'b0, asf_pkg::PBC_ADDR, 32'h1);
    wr(1'b0, asf_pkg::CPC_ADDR, 32'h3);
    stream(16'h0153, 16'h0006, 32'h1D3, 32'h8000_0000, 32'h1234_0000, 32'h5555_5555,
           32'h0001_0000, 32'hEDCC_0000, 32'h7FFF_0000, 32'hFFFF_0000);
  endtask : dsp_b_negated
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    regs_after_reset();
    i2s_default();
    lj_inverted();
    dsp_a_dev_master();
    dsp_b_negated();
    print_verdict();
  end
endmodule : tb_audio_serial_format_engine
`default_nettype wire
